// ### verilog/bfx_defines.svh
`ifndef BFX_DEFINES_SVH
`define BFX_DEFINES_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SRC 8'h04
`define OFS_DST 8'h08
`define OFS_OFFSET 8'h0c
`define OFS_PC 8'h10
`define OFS_PSW 8'h14
`define OFS_LINK 8'h18
`define OFS_EVENT 8'h1c
// Instruction word fields
`define F_OP 4:0
`define F_LSB 9:5
`define F_WIDTH 15:10
`define F_ROT 17:16
`define F_SATN 23:18
`define F_COND 27:24
`define F_WIDE 28
`define F_ITMASK 31:29
// Status word: flags in bits 31..27, N Z C V Q
`define PSW_HI 31
`define PSW_PAD 27'h0000000
`define Q_BIT 0
// Event register bits
`define EV_MISUSE 0
`define EV_RANGE 1
`define EV_PLACE 2
// Condition codes and sizes
`define COND_ALWAYS 3'h7
`define SZ_NARROW 32'h00000002
`define SZ_WIDE 32'h00000004
`define IT_MAX 3'h4
// Branch reach in bytes: 16 MB and 1 MB
`define REACH_WIDE 32'sh01000000
`define REACH_NEAR 32'sh00100000
// Reset values
`define RST_WORD 32'h00000000
`define RST_PSW 5'h00
`endif

// ### verilog/bfx_pkg.sv
package bfx_pkg;
	typedef enum logic [4:0] {
		OP_NOP, OP_SCLAMP, OP_UCLAMP, OP_FCLR, OP_FINS, OP_SFX, OP_UFX,
		OP_BSX, OP_BZX, OP_HSX, OP_HZX, OP_JMP, OP_CJMP, OP_CALL,
		OP_JREG, OP_CREG, OP_PRED
	} op_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [31:0] ctrl;
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] offset;
		logic [31:0] pc;
		logic [31:0] lr;
		logic [4:0] psw;
		logic [2:0] evt;
		logic [3:0] it_cond;
		logic [2:0] it_mask;
		logic it_inv;
		logic [2:0] it_left;
		logic fault;
		logic taken;
	} state_t;

	// Ones in the low width bits; width 32 gives all ones
	function automatic logic [31:0] low_mask(input logic [5:0] width);
		return (width >= 6'd32) ? 32'hffffffff : ((32'h1 << width) - 32'h1);
	endfunction
endpackage

// ### verilog/bfx_unit.sv
`timescale 1ns/1ps
module bfx_unit (
	// Decoded operation
	input wire bfx_pkg::op_t op,
	input wire logic [4:0] lsb,
	input wire logic [5:0] width,
	input wire logic [1:0] rot,
	input wire logic [5:0] satn,
	// Operands
	input wire logic [31:0] src,
	input wire logic [31:0] dst,
	// Result
	output logic [31:0] result,
	output logic saturated
);
	import bfx_pkg::*;

	logic [31:0] m;
	logic [31:0] fm;
	logic [31:0] f;
	logic [31:0] r;
	logic signed [33:0] v;
	logic signed [33:0] hi;
	logic signed [33:0] lo;

	// Field masks, extract and rotate shared by all forms
	always_comb begin
		m = low_mask(width);
		fm = m << lsb;
		f = (src >> lsb) & m;
		r = (src >> {rot, 3'b000}) | (src << (6'd32 - {1'b0, rot, 3'b000}));
		v = {{2{src[31]}}, src};
		if (op == OP_SCLAMP) begin
			hi = (34'sd1 <<< (satn - 6'd1)) - 34'sd1;
			lo = -hi - 34'sd1;
		end else begin
			hi = (34'sd1 <<< satn) - 34'sd1;
			lo = 34'sd0;
		end
		saturated = 1'b0;
		result = dst;
		unique case (op)
			OP_SCLAMP, OP_UCLAMP: begin
				saturated = (v > hi) || (v < lo);
				result = (v > hi) ? hi[31:0] : (v < lo) ? lo[31:0] : src;
			end
			OP_FCLR: result = dst & ~fm;
			OP_FINS: result = (dst & ~fm) | ((src & m) << lsb);
			OP_SFX: result = f[5'(width - 6'd1)] ? (f | ~m) : f;
			OP_UFX: result = f;
			OP_BSX: result = {{24{r[7]}}, r[7:0]};
			OP_BZX: result = {24'h000000, r[7:0]};
			OP_HSX: result = {{16{r[15]}}, r[15:0]};
			OP_HZX: result = {16'h0000, r[15:0]};
			default: result = dst;
		endcase
	end
endmodule // bfx_unit

// ### verilog/bfx_exec.sv
// Operation
// - Clamp operations leave N, Z, C and V untouched.
// - A clamp whose result differs from its input sets the sticky Q.
// - Field clear zeroes width bits from lsb, other bits kept.
// - Field insert copies source low bits into width bits at lsb.
// - lsb is 0 to 31 and width 1 to 32-lsb.
// - Signed extract sign-extends the chosen field to 32 bits.
// - Unsigned extract zero-extends the chosen field to 32 bits.
// - Extends rotate the source right by 0, 8, 16 or 24 first.
// - Byte extends take bits 7..0, signed or unsigned.
// - Half extends take bits 15..0, signed or unsigned.
// - Bitfield and extend operations change no flag.
// - Both calls load the return address with the next address.
// - Register branches jump to the register value with bit 0 cleared.
// - Register branch with bit 0 low raises the misuse fault.
// - Reach 16 MB, or 1 MB for a conditional jump outside a block.
// - Only the conditional jump is conditional outside a block.
// - Branches and calls change no flag.
// - Q stays set until software writes the status word.
// - A predicate prefix makes up to four following instructions conditional.
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "bfx_defines.svh"
module bfx_exec (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// Events
	output logic misuse_fault,
	output logic branch_taken
);
	import bfx_pkg::*;

	state_t st;
	state_t next_st;

	logic acc;
	logic wr;
	logic issue;
	logic [31:0] wdata;
	logic [31:0] word;
	op_t op;
	logic in_it;
	logic [3:0] cond;
	logic pass;
	logic [31:0] nsize;
	logic [31:0] nxt_addr;
	logic [31:0] rel_target;
	logic in_wide;
	logic in_near;
	logic is_branch;
	logic is_reg_br;
	logic [31:0] unit_res;
	logic unit_sat;
	logic [31:0] fmask;
	logic [2:0] it_count;
	logic [31:0] psw_word;

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Condition test against N Z C V (psw bits 4..1)
	function automatic logic cond_ok(input logic [3:0] c, input logic [4:0] f);
		logic r;
		r = 1'b1;
		unique case (c[3:1])
			3'h0: r = f[3];
			3'h1: r = f[2];
			3'h2: r = f[4];
			3'h3: r = f[1];
			3'h4: r = f[2] && !f[3];
			3'h5: r = (f[4] == f[1]);
			3'h6: r = !f[3] && (f[4] == f[1]);
			3'h7: r = 1'b1;
		endcase
		return (c[3:1] == `COND_ALWAYS) ? 1'b1 : (r ^ c[0]);
	endfunction

	// Bus handshake terms; writes land on the edge that sees ack high
	assign acc = wb_cyc_i && wb_stb_i;
	assign wr = acc && st.ack && wb_we_i;
	assign issue = wr && (wb_adr_i == `OFS_CTRL);
	assign word = merge(st.ctrl, wb_dat_i, wb_sel_i);
	assign psw_word = merge({st.psw, `PSW_PAD}, wb_dat_i, wb_sel_i);
	assign op = op_t'(word[`F_OP]);

	// Predication: inside a block the block condition rules
	assign in_it = (st.it_left != 3'h0);
	assign cond = in_it ? {st.it_cond[3:1], st.it_cond[0] ^ st.it_inv} : word[`F_COND];
	assign pass = in_it ? cond_ok(cond, st.psw) :
		((op == OP_CJMP) ? cond_ok(cond, st.psw) : 1'b1);

	// Addresses and reach of relative branches
	assign nsize = word[`F_WIDE] ? `SZ_WIDE : `SZ_NARROW;
	assign nxt_addr = st.pc + nsize;
	assign rel_target = st.pc + st.offset;
	assign in_wide = ($signed(st.offset) >= -`REACH_WIDE) && ($signed(st.offset) < `REACH_WIDE);
	assign in_near = ($signed(st.offset) >= -`REACH_NEAR) && ($signed(st.offset) < `REACH_NEAR);
	assign is_reg_br = (op == OP_JREG) || (op == OP_CREG);
	assign is_branch = is_reg_br || (op == OP_JMP) || (op == OP_CJMP) || (op == OP_CALL);
	assign fmask = low_mask(word[`F_WIDTH]) << word[`F_LSB];
	assign it_count = (word[7:5] == 3'h0 || word[7:5] > `IT_MAX) ? `IT_MAX : word[7:5];

	// Field and extend datapath
	bfx_unit u_unit (
		.op(op),
		.lsb(word[`F_LSB]),
		.width(word[`F_WIDTH]),
		.rot(word[`F_ROT]),
		.satn(word[`F_SATN]),
		.src(st.src),
		.dst(st.dst),
		.result(unit_res),
		.saturated(unit_sat)
	);

	// Whole next state: bus slave, registers and execution
	always_comb begin
		wdata = merge(32'h00000000, wb_dat_i, wb_sel_i);
		next_st = st;
		next_st.fault = 1'b0;
		next_st.taken = 1'b0;
		// Ack is a one-cycle pulse, so back-to-back requests are spaced
		next_st.ack = acc && !st.ack;
		if (acc && !st.ack) begin
			unique case (wb_adr_i)
				`OFS_CTRL: next_st.rdata = st.ctrl;
				`OFS_SRC: next_st.rdata = st.src;
				`OFS_DST: next_st.rdata = st.dst;
				`OFS_OFFSET: next_st.rdata = st.offset;
				`OFS_PC: next_st.rdata = st.pc;
				`OFS_PSW: next_st.rdata = {st.psw, `PSW_PAD};
				`OFS_LINK: next_st.rdata = st.lr;
				`OFS_EVENT: next_st.rdata = {25'h0000000, st.it_left, 1'b0, st.evt};
				default: next_st.rdata = 32'h00000000;
			endcase
		end
		// Plain register writes; clears come before any set below
		if (wr) begin
			unique case (wb_adr_i)
				`OFS_SRC: next_st.src = merge(st.src, wb_dat_i, wb_sel_i);
				`OFS_DST: next_st.dst = merge(st.dst, wb_dat_i, wb_sel_i);
				`OFS_OFFSET: next_st.offset = merge(st.offset, wb_dat_i, wb_sel_i);
				`OFS_PC: next_st.pc = merge(st.pc, wb_dat_i, wb_sel_i);
				`OFS_PSW: next_st.psw = psw_word[`PSW_HI -: 5];
				`OFS_EVENT: next_st.evt = st.evt & ~wdata[2:0];
				default: next_st.ctrl = st.ctrl;
			endcase
		end
		// Issue on a control write; N Z C V are never touched here, only Q
		if (issue) begin
			next_st.ctrl = word;
			next_st.pc = nxt_addr;
			if (in_it && op != OP_PRED) begin
				next_st.it_left = st.it_left - 3'h1;
				next_st.it_inv = st.it_mask[0];
				next_st.it_mask = {1'b0, st.it_mask[2:1]};
			end
			// A branch must close its block; flag one that is not last, and end the block
			if (in_it && is_branch) begin
				if (st.it_left != 3'h1) begin
					next_st.evt[`EV_PLACE] = 1'b1;
				end
				next_st.it_left = 3'h0;
			end
			// A prefix inside a block is refused whatever its condition
			if (in_it && op == OP_PRED) begin
				next_st.evt[`EV_PLACE] = 1'b1;
			end
			if (pass) begin
				unique case (op)
					OP_SCLAMP, OP_UCLAMP: begin
						next_st.dst = unit_res;
						if (unit_sat) begin
							next_st.psw[`Q_BIT] = 1'b1;
						end
					end
					// Operands beyond the legal lsb and width give an undefined field
					OP_FCLR, OP_FINS: next_st.dst = unit_res;
					OP_SFX, OP_UFX: next_st.dst = unit_res;
					OP_BSX, OP_BZX: next_st.dst = unit_res;
					OP_HSX, OP_HZX: next_st.dst = unit_res;
					OP_JMP, OP_CJMP, OP_CALL: begin
						// Near reach only for a conditional jump outside a block
						if ((op == OP_CJMP && !in_it) ? in_near : in_wide) begin
							next_st.pc = rel_target;
							next_st.taken = 1'b1;
							if (op == OP_CALL) begin
								next_st.lr = nxt_addr;
							end
						end else begin
							next_st.evt[`EV_RANGE] = 1'b1;
						end
					end
					OP_JREG, OP_CREG: begin
						if (st.src[0]) begin
							next_st.pc = {st.src[31:1], 1'b0};
							next_st.taken = 1'b1;
							if (op == OP_CREG) begin
								next_st.lr = nxt_addr;
							end
						end else begin
							// Fault holds pc at the offending instruction
							next_st.pc = st.pc;
							next_st.fault = 1'b1;
							next_st.evt[`EV_MISUSE] = 1'b1;
						end
					end
					OP_PRED: begin
						if (in_it) begin
							next_st.evt[`EV_PLACE] = 1'b1;
						end else begin
							next_st.it_cond = word[`F_COND];
							next_st.it_mask = word[`F_ITMASK];
							next_st.it_inv = 1'b0;
							next_st.it_left = it_count;
						end
					end
					OP_NOP: next_st.pc = nxt_addr;
					default: next_st.pc = nxt_addr;
				endcase
			end
		end
	end

	// Single state register, frozen while ce is low
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Outputs straight from state flops
	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.rdata;
	assign misuse_fault = st.fault;
	assign branch_taken = st.taken;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst || !ce);

	sequence s_request;
		acc && !st.ack;
	endsequence

	sequence s_reg_branch;
		issue && pass && is_reg_br;
	endsequence

	// Ack answers one cycle after a request and lasts one cycle
	property p_ack_pulse;
		s_request |=> st.ack ##1 !st.ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");

	property p_flags_hold;
		issue |=> st.psw[4:1] == $past(st.psw[4:1]);
	endproperty
	a_flags_hold: assert property (p_flags_hold) else $error("flags changed");

	property p_q_set;
		issue && pass && (op == OP_SCLAMP || op == OP_UCLAMP) && unit_sat |=> st.psw[0];
	endproperty
	a_q_set: assert property (p_q_set) else $error("Q not set");

	property p_q_sticky;
		st.psw[0] && !(wr && wb_adr_i == `OFS_PSW)
			|=> st.psw[0] ##1 (st.psw[0] || $past(wr && wb_adr_i == `OFS_PSW));
	endproperty
	a_q_sticky: assert property (p_q_sticky) else $error("Q lost");

	property p_clear;
		issue && pass && op == OP_FCLR |=> ((st.dst & $past(fmask)) == 32'h00000000)
			&& ((st.dst & ~$past(fmask)) == ($past(st.dst) & ~$past(fmask)));
	endproperty
	a_clear: assert property (p_clear) else $error("field clear wrong");

	property p_call_link;
		issue && pass && op == OP_CREG && st.src[0] |=> st.lr == $past(nxt_addr) && st.taken;
	endproperty
	a_call_link: assert property (p_call_link) else $error("link not loaded");

	property p_misuse;
		s_reg_branch and !st.src[0] |=> st.fault && st.pc == $past(st.pc) ##1 !st.fault;
	endproperty
	a_misuse: assert property (p_misuse) else $error("misuse fault missing");

	property p_reg_target;
		s_reg_branch and st.src[0] |=> !st.pc[0] && st.pc[31:1] == $past(st.src[31:1]);
	endproperty
	a_reg_target: assert property (p_reg_target) else $error("bad register target");

	property p_near_reach;
		issue && pass && op == OP_CJMP && !in_it && !in_near |=> st.evt[1] && !st.taken;
	endproperty
	a_near_reach: assert property (p_near_reach) else $error("near reach ignored");

	property p_pred_len;
		issue && op == OP_PRED && !in_it |=> st.it_left == $past(it_count) && st.it_left <= 3'h4;
	endproperty
	a_pred_len: assert property (p_pred_len) else $error("block length wrong");

	property p_wide_reach;
		issue && pass && (op == OP_JMP || op == OP_CALL) && !in_wide
			|=> st.evt[`EV_RANGE] && !st.taken;
	endproperty
	a_wide_reach: assert property (p_wide_reach) else $error("wide reach ignored");

	property p_misplaced;
		issue && in_it && is_branch && st.it_left != 3'h1
			|=> st.evt[`EV_PLACE] && st.it_left == 3'h0;
	endproperty
	a_misplaced: assert property (p_misplaced) else $error("placement not flagged");

	property p_fault_no_link;
		s_reg_branch and !st.src[0] |=> st.lr == $past(st.lr) && !st.taken;
	endproperty
	a_fault_no_link: assert property (p_fault_no_link) else $error("link moved");

	property p_byte_zero;
		issue && pass && op == OP_BZX |=> st.dst[31:8] == 24'h000000;
	endproperty
	a_byte_zero: assert property (p_byte_zero) else $error("byte zero fill wrong");

	property p_half_sign;
		issue && pass && op == OP_HSX |=> st.dst[31:16] == {16{st.dst[15]}};
	endproperty
	a_half_sign: assert property (p_half_sign) else $error("half sign fill wrong");

	property p_extract_zero;
		issue && pass && op == OP_UFX
			|=> (st.dst & ~$past(low_mask(word[`F_WIDTH]))) == 32'h00000000;
	endproperty
	a_extract_zero: assert property (p_extract_zero) else $error("extract not zero");

	property p_q_hold;
		!(issue && pass && unit_sat) && !(wr && wb_adr_i == `OFS_PSW)
			|=> st.psw[0] == $past(st.psw[0]);
	endproperty
	a_q_hold: assert property (p_q_hold) else $error("Q changed alone");
endmodule // bfx_exec

// ### verification/bfx_exec_tb_top.sv
`timescale 1ns/1ps
`include "bfx_defines.svh"
module bfx_exec_tb_top;
	import bfx_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic wb_ack_o;
	logic [31:0] wb_dat_o;
	logic misuse_fault;
	logic branch_taken;
	int n_mismatch = 0;
	int check_count = 0;
	int n_taken = 0;
	int n_fault = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// Pulse counters; a stuck pulse shows up as extra counts
	always @(posedge clk) begin
		if (branch_taken === 1'b1) n_taken++;
		if (misuse_fault === 1'b1) n_fault++;
	end

	bfx_exec u_dut (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o),
		.misuse_fault(misuse_fault),
		.branch_taken(branch_taken)
	);

	task automatic test_done();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic cycle; ack and read data are taken at the same edge
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
			output logic [31:0] q);
		int i;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= dat;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (wb_ack_o === 1'b1) break;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (i == 20) begin
			n_mismatch++;
			test_done();
		end
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] q;
		wb_cycle(1'b1, adr, dat, q);
	endtask

	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] q;
		wb_cycle(1'b0, adr, 32'h0, q);
		check(q, exp);
	endtask

	function automatic logic [31:0] mk(input op_t op, input logic [4:0] lsb,
			input logic [5:0] w, input logic [1:0] rot, input logic [5:0] satn,
			input logic [3:0] cond, input logic wide);
		return {3'h0, wide, cond, satn, rot, w, lsb, op};
	endfunction

	// Operand in, one instruction, destination read back
	task automatic run(input op_t op, input logic [4:0] lsb, input logic [5:0] w,
			input logic [1:0] rot, input logic [5:0] satn, input logic [31:0] s,
			input logic [31:0] d, input logic [31:0] exp);
		wr(`OFS_SRC, s);
		wr(`OFS_DST, d);
		wr(`OFS_CTRL, mk(op, lsb, w, rot, satn, 4'he, 1'b0));
		rdchk(`OFS_DST, exp);
	endtask

	task automatic t_bitfield();
		wr(`OFS_PSW, 32'ha0000000);
		run(OP_FCLR, 5'd8, 6'd12, 2'd0, 6'd0, 32'h0, 32'hffffffff, 32'hfff000ff);
		run(OP_FINS, 5'd8, 6'd12, 2'd0, 6'd0, 32'hfffffabc, 32'h0, 32'h000abc00);
		run(OP_FINS, 5'd0, 6'd32, 2'd0, 6'd0, 32'h12345678, 32'h0, 32'h12345678);
		run(OP_FCLR, 5'd31, 6'd1, 2'd0, 6'd0, 32'h0, 32'hffffffff, 32'h7fffffff);
		run(OP_SFX, 5'd20, 6'd4, 2'd0, 6'd0, 32'h00800000, 32'h0, 32'hfffffff8);
		run(OP_UFX, 5'd9, 6'd10, 2'd0, 6'd0, 32'hfffffe00, 32'h0, 32'h000003ff);
		rdchk(`OFS_PSW, 32'ha0000000);
	endtask

	task automatic t_extend();
		logic [31:0] s;
		logic [31:0] v;
		int r;
		s = 32'h12f4a583;
		for (r = 0; r < 4; r++) begin
			v = (s >> (8 * r)) | (s << (32 - 8 * r));
			run(OP_BSX, 5'd0, 6'd0, r[1:0], 6'd0, s, 32'h0, {{24{v[7]}}, v[7:0]});
			run(OP_BZX, 5'd0, 6'd0, r[1:0], 6'd0, s, 32'h0, {24'h0, v[7:0]});
			run(OP_HSX, 5'd0, 6'd0, r[1:0], 6'd0, s, 32'h0, {{16{v[15]}}, v[15:0]});
			run(OP_HZX, 5'd0, 6'd0, r[1:0], 6'd0, s, 32'h0, {16'h0, v[15:0]});
		end
	endtask

	task automatic t_clamp();
		wr(`OFS_PSW, 32'h50000000);
		run(OP_SCLAMP, 5'd0, 6'd0, 2'd0, 6'd8, 32'h00000020, 32'h0, 32'h00000020);
		rdchk(`OFS_PSW, 32'h50000000);
		run(OP_SCLAMP, 5'd0, 6'd0, 2'd0, 6'd8, 32'h00001000, 32'h0, 32'h0000007f);
		rdchk(`OFS_PSW, 32'h58000000);
		run(OP_UFX, 5'd0, 6'd4, 2'd0, 6'd0, 32'h0, 32'h0, 32'h0);
		rdchk(`OFS_PSW, 32'h58000000);
		wr(`OFS_PSW, 32'h50000000);
		rdchk(`OFS_PSW, 32'h50000000);
		run(OP_UCLAMP, 5'd0, 6'd0, 2'd0, 6'd8, 32'hffffff00, 32'h5, 32'h00000000);
		rdchk(`OFS_PSW, 32'h58000000);
	endtask

	// Branch with given offset or register operand, then pc check
	task automatic br(input op_t op, input logic [3:0] cond, input logic wide,
			input logic [31:0] opnd, input logic [31:0] exp_pc);
		wr(`OFS_OFFSET, opnd);
		wr(`OFS_SRC, opnd);
		wr(`OFS_CTRL, mk(op, 5'd0, 6'd0, 2'd0, 6'd0, cond, wide));
		rdchk(`OFS_PC, exp_pc);
	endtask

	task automatic t_branch();
		wr(`OFS_PSW, 32'hf0000000);
		wr(`OFS_PC, 32'h00000100);
		br(OP_CALL, 4'he, 1'b0, 32'h00000040, 32'h00000140);
		rdchk(`OFS_LINK, 32'h00000102);
		br(OP_JREG, 4'he, 1'b0, 32'h00002001, 32'h00002000);
		br(OP_CREG, 4'he, 1'b1, 32'h00003001, 32'h00003000);
		rdchk(`OFS_LINK, 32'h00002004);
		check(n_taken, 3);
		br(OP_CREG, 4'he, 1'b0, 32'h00004000, 32'h00003000);
		rdchk(`OFS_LINK, 32'h00002004);
		rdchk(`OFS_EVENT, 32'h00000001);
		check(n_fault, 1);
		wr(`OFS_EVENT, 32'h7);
		br(OP_CJMP, 4'he, 1'b0, 32'h00100000, 32'h00003002);
		rdchk(`OFS_EVENT, 32'h00000002);
		wr(`OFS_EVENT, 32'h7);
		br(OP_CJMP, 4'h1, 1'b0, 32'h00000040, 32'h00003004);
		br(OP_JMP, 4'h1, 1'b0, 32'h00100000, 32'h00103004);
		check(n_taken, 4);
		rdchk(`OFS_PSW, 32'hf0000000);
	endtask

	task automatic t_block();
		wr(`OFS_PC, 32'h00001000);
		wr(`OFS_CTRL, mk(OP_PRED, 5'd2, 6'd0, 2'd0, 6'd0, 4'h0, 1'b0));
		wr(`OFS_CTRL, mk(OP_NOP, 5'd0, 6'd0, 2'd0, 6'd0, 4'h0, 1'b0));
		br(OP_JMP, 4'h0, 1'b0, 32'h00000100, 32'h00001104);
		wr(`OFS_CTRL, mk(OP_PRED, 5'd1, 6'd0, 2'd0, 6'd0, 4'h0, 1'b0));
		br(OP_CJMP, 4'h0, 1'b0, 32'h00100000, 32'h00101106);
		wr(`OFS_CTRL, mk(OP_PRED, 5'd2, 6'd0, 2'd0, 6'd0, 4'h0, 1'b0));
		wr(`OFS_CTRL, mk(OP_JMP, 5'd0, 6'd0, 2'd0, 6'd0, 4'h0, 1'b0));
		rdchk(`OFS_EVENT, 32'h00000004);
		wr(`OFS_EVENT, 32'h7);
		wr(`OFS_PC, 32'h00002000);
		wr(`OFS_CTRL, mk(OP_PRED, 5'd3, 6'd0, 2'd0, 6'd0, 4'h1, 1'b0));
		rdchk(`OFS_EVENT, 32'h00000030);
		wr(`OFS_CTRL, mk(OP_NOP, 5'd0, 6'd0, 2'd0, 6'd0, 4'h1, 1'b0));
		wr(`OFS_CTRL, mk(OP_NOP, 5'd0, 6'd0, 2'd0, 6'd0, 4'h1, 1'b0));
		br(OP_JMP, 4'h1, 1'b0, 32'h00000100, 32'h00002008);
		rdchk(`OFS_EVENT, 32'h00000000);
		// Else mask: second slot runs on the inverse, so this jump must fail
		wr(`OFS_PC, 32'h00003000);
		wr(`OFS_CTRL, mk(OP_PRED, 5'd2, 6'd0, 2'd0, 6'd0, 4'h0, 1'b0) | 32'h20000000);
		wr(`OFS_CTRL, mk(OP_NOP, 5'd0, 6'd0, 2'd0, 6'd0, 4'h0, 1'b0));
		br(OP_JMP, 4'h1, 1'b0, 32'h00000100, 32'h00003006);
	endtask

	// Reset held 20 cycles, then all scenarios in turn
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rdchk(`OFS_PC, 32'h0);
		rdchk(`OFS_PSW, 32'h0);
		rdchk(`OFS_LINK, 32'h0);
		rdchk(8'h40, 32'h0);
		t_bitfield();
		t_extend();
		t_clamp();
		t_branch();
		t_block();
		check(n_taken, 7);
		test_done();
	end
endmodule // bfx_exec_tb_top
